// ===== design/tmz_divider.sv
// Purpose: shared power-of-two divider for timer or watchdog
// Assumes: tickIn is a one-cycle pulse
// Notes:   count cannot be read or loaded; a write to the timer count clears it when ahead of the timer
`timescale 1ns/1ps
module tmz_divider import tmz_pkg::*; #(
	parameter int W = 8
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       tickIn,
	input  wire logic       clear,
	input  wire logic       toWatchdog,
	input  wire logic [2:0] ratio,
	output logic            tickOut
);
	tmz_div_state_s state;
	tmz_div_state_s next_state;
	logic [3:0]     shift;
	logic [W-1:0]   mask;

	function automatic logic [W-1:0] lowMask(input logic [3:0] n);
		logic [W:0] m;
		m = ({{W{1'b0}}, 1'b1} << n) - {{W{1'b0}}, 1'b1};
		return m[W-1:0];
	endfunction : lowMask

	// one extra stage when ahead of the timer gives 1:2..1:256
	assign shift   = {1'b0, ratio} + {3'b000, ~toWatchdog};
	assign mask    = lowMask(shift);
	assign tickOut = tickIn && !clear && ((state.cnt & mask) == mask);

	// clear beats a tick in the same cycle
	always_comb begin
		next_state = state;
		if (clear) begin
			next_state.cnt = '0;
		end else if (tickIn) begin
			next_state.cnt = state.cnt + 8'h01;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	property p_div_clear;
		@(posedge clk) disable iff (reset) clear |=> state.cnt == 8'h00;
	endproperty
	a_div_clear: assert property (p_div_clear) else $error("divider not cleared");

	property p_div_half;
		@(posedge clk) disable iff (reset)
		(!toWatchdog && ratio == 3'h0 && tickIn && !state.cnt[0]) |-> !tickOut;
	endproperty
	a_div_half: assert property (p_div_half) else $error("divider 1:2 wrong");
endmodule : tmz_divider

// ===== design/tmz_edge_sync.sv
// Purpose: two-stage synchroniser and edge detector for the count pin
// Assumes: pin may change at any time
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module tmz_edge_sync import tmz_pkg::*; (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic pin,
	output logic      risePulse,
	output logic      fallPulse
);
	tmz_sync_state_s state;
	tmz_sync_state_s next_state;

	// shift chain; edges are judged on the settled stages only
	always_comb begin
		next_state      = state;
		next_state.meta = pin;
		next_state.sync = state.meta;
		next_state.prev = state.sync;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign risePulse = state.sync & ~state.prev;
	assign fallPulse = ~state.sync & state.prev;
endmodule : tmz_edge_sync

// ===== design/tmz_pkg.sv
// Purpose: types shared by the timer modules
// Assumes: field layouts match the register map header
// Notes:   option struct mirrors the option register bit order
package tmz_pkg;

	typedef enum logic [1:0] {
		TMZ_INH_IDLE  = 2'b00,
		TMZ_INH_HOLD2 = 2'b01,
		TMZ_INH_HOLD1 = 2'b11
	} tmz_inh_e;

	typedef enum logic [2:0] {
		TMZ_SEL_NONE,
		TMZ_SEL_COUNT,
		TMZ_SEL_INTCTL,
		TMZ_SEL_OPTION,
		TMZ_SEL_PORTA
	} tmz_sel_e;

	typedef struct packed {
		logic [8:0] addr;
		logic [7:0] wrData;
		logic       wrStrobe;
		logic       rdStrobe;
	} tmz_bus_req_s;

	typedef struct packed {
		logic       pullupOff;
		logic       intEdge;
		logic       clockSourceSelect;
		logic       countEdgeSelect;
		logic       dividerAssignment;
		logic [2:0] dividerRatio;
	} tmz_option_s;

	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
	} tmz_sync_state_s;

	typedef struct packed {
		logic [7:0] cnt;
	} tmz_div_state_s;

	typedef struct packed {
		logic [7:0]  count;
		logic [7:0]  intCtl;
		tmz_option_s option;
		logic [5:0]  portADir;
		tmz_inh_e    inh;
		logic [7:0]  instrCnt;
		logic [7:0]  rdData;
		logic        irq;
		logic        wdtTimeout;
	} tmz_state_s;

endpackage : tmz_pkg

// ===== design/tmz_regs.svh
// Purpose: register map, field positions, reset values and timing of the timer
// Assumes: one clk at 50 MHz, registers reached over a plain strobe port
// Notes:   included by its bare name; definitions only
`ifndef TMZ_REGS_SVH
`define TMZ_REGS_SVH

`define TMZ_ADDR_COUNT      9'h001
`define TMZ_ADDR_COUNT_MIR  9'h101
`define TMZ_ADDR_INTCTL     9'h00b
`define TMZ_ADDR_INTCTL_M1  9'h08b
`define TMZ_ADDR_INTCTL_M2  9'h10b
`define TMZ_ADDR_INTCTL_M3  9'h18b
`define TMZ_ADDR_OPTION     9'h081
`define TMZ_ADDR_OPTION_MIR 9'h181
`define TMZ_ADDR_PORTA_DIR  9'h085

`define TMZ_BIT_OVF_FLAG    2
`define TMZ_BIT_OVF_EN      5

`define TMZ_RST_COUNT       8'h00
`define TMZ_RST_INTCTL      8'h00
`define TMZ_RST_OPTION      8'hff
`define TMZ_RST_PORTA_DIR   6'h3f

`define TMZ_CLK_NS          20
`define TMZ_INSTR_NS        200
`define TMZ_INSTR_CYC       ((`TMZ_INSTR_NS) / (`TMZ_CLK_NS))

`endif

// ===== design/tmz_timer.sv
// Purpose: 8-bit timer/counter with shared divider and overflow interrupt
// Assumes: bus strobes one cycle long; count pin sampled on clk
// Notes:   instruction cycle is an enable pulse from an internal divider
`timescale 1ns/1ps
`include "tmz_regs.svh"
module tmz_timer import tmz_pkg::*; #(
	parameter int INSTR_CYC = `TMZ_INSTR_CYC
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire tmz_bus_req_s busReq,
	output logic [7:0]        rdData,
	input  wire logic         extCountPin,
	input  wire logic         sleepMode,
	input  wire logic         wdtTick,
	input  wire logic         wdtClear,
	output logic              wdtTimeout,
	output logic              irq,
	output logic [5:0]        portADir
);
	tmz_state_s state;
	tmz_state_s next_state;
	tmz_sel_e   sel;
	logic       instrTick;
	logic       risePulse;
	logic       fallPulse;
	logic       srcTick;
	logic       divIn;
	logic       divClear;
	logic       divOut;
	logic       incTick;
	logic       wrCount;
	logic       ovfSet;

	// address decode; every mirror lands on the same register
	function automatic tmz_sel_e decode(input logic [8:0] a);
		case (a)
			`TMZ_ADDR_COUNT,
			`TMZ_ADDR_COUNT_MIR:  decode = TMZ_SEL_COUNT;
			`TMZ_ADDR_INTCTL,
			`TMZ_ADDR_INTCTL_M1,
			`TMZ_ADDR_INTCTL_M2,
			`TMZ_ADDR_INTCTL_M3:  decode = TMZ_SEL_INTCTL;
			`TMZ_ADDR_OPTION,
			`TMZ_ADDR_OPTION_MIR: decode = TMZ_SEL_OPTION;
			`TMZ_ADDR_PORTA_DIR:  decode = TMZ_SEL_PORTA;
			default:              decode = TMZ_SEL_NONE;
		endcase
	endfunction : decode

	// count pin enters through the synchroniser only
	tmz_edge_sync u_sync (
		.clk       (clk),
		.reset     (reset),
		.pin       (extCountPin),
		.risePulse (risePulse),
		.fallPulse (fallPulse)
	);

	// the one divider, steered by the assignment bit
	tmz_divider #(
		.W (8)
	) u_div (
		.clk        (clk),
		.reset      (reset),
		.tickIn     (divIn),
		.clear      (divClear),
		.toWatchdog (state.option.dividerAssignment),
		.ratio      (state.option.dividerRatio),
		.tickOut    (divOut)
	);

	assign sel       = decode(busReq.addr);
	assign wrCount   = busReq.wrStrobe && (sel == TMZ_SEL_COUNT);
	assign instrTick = (state.instrCnt == 8'(INSTR_CYC - 1));

	// source tick; sleep stops both timer and counter modes
	always_comb begin
		if (sleepMode) begin
			srcTick = 1'b0;
		end else if (state.option.clockSourceSelect) begin
			srcTick = state.option.countEdgeSelect ? fallPulse : risePulse;
		end else begin
			srcTick = instrTick;
		end
	end

	// divider routing; the watchdog keeps its ticks through sleep
	always_comb begin
		if (state.option.dividerAssignment) begin
			divIn    = wdtTick;
			divClear = wdtClear;
			incTick  = srcTick;
		end else begin
			divIn    = srcTick;
			divClear = wrCount;
			incTick  = divOut;
		end
	end

	assign ovfSet = !wrCount && (state.inh == TMZ_INH_IDLE) && incTick
		&& (state.count == 8'hff);

	// all register, counter and bus behaviour
	always_comb begin
		next_state = state;

		// instruction-cycle enable divider
		if (instrTick) begin
			next_state.instrCnt = 8'h00;
		end else begin
			next_state.instrCnt = state.instrCnt + 8'h01;
		end

		// count: a write wins, then the hold-off, then increments
		if (wrCount) begin
			next_state.count = busReq.wrData;
			next_state.inh   = TMZ_INH_HOLD2;
		end else if (state.inh != TMZ_INH_IDLE) begin
			if (instrTick) begin
				case (state.inh)
					TMZ_INH_HOLD2: next_state.inh = TMZ_INH_HOLD1;
					TMZ_INH_HOLD1: next_state.inh = TMZ_INH_IDLE;
					default:       next_state.inh = TMZ_INH_IDLE;
				endcase
			end
		end else if (incTick) begin
			next_state.count = state.count + 8'h01;
		end

		// interrupt control; flag is write-one-to-clear, set wins
		if (busReq.wrStrobe && sel == TMZ_SEL_INTCTL) begin
			next_state.intCtl = busReq.wrData;
			next_state.intCtl[`TMZ_BIT_OVF_FLAG] = state.intCtl[`TMZ_BIT_OVF_FLAG]
				& ~busReq.wrData[`TMZ_BIT_OVF_FLAG];
		end
		if (ovfSet) begin
			next_state.intCtl[`TMZ_BIT_OVF_FLAG] = 1'b1;
		end

		// option changes take effect at once, nothing is reset
		if (busReq.wrStrobe && sel == TMZ_SEL_OPTION) begin
			next_state.option = tmz_option_s'(busReq.wrData);
		end
		if (busReq.wrStrobe && sel == TMZ_SEL_PORTA) begin
			next_state.portADir = busReq.wrData[5:0];
		end

		// read data stand for one cycle only
		next_state.rdData = 8'h00;
		if (busReq.rdStrobe) begin
			case (sel)
				TMZ_SEL_COUNT:  next_state.rdData = state.count;
				TMZ_SEL_INTCTL: next_state.rdData = state.intCtl;
				TMZ_SEL_OPTION: next_state.rdData = state.option;
				TMZ_SEL_PORTA:  next_state.rdData = {2'b00, state.portADir};
				default:        next_state.rdData = 8'h00;
			endcase
		end

		// irq follows the flag in the same cycle it is stored
		next_state.irq = next_state.intCtl[`TMZ_BIT_OVF_FLAG]
			&& next_state.intCtl[`TMZ_BIT_OVF_EN];

		// without the divider the watchdog tick passes straight out
		next_state.wdtTimeout = state.option.dividerAssignment ? divOut : wdtTick;
	end

	// single state register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state          <= '0;
			state.count    <= `TMZ_RST_COUNT;
			state.intCtl   <= `TMZ_RST_INTCTL;
			state.option   <= `TMZ_RST_OPTION;
			state.portADir <= `TMZ_RST_PORTA_DIR;
			state.inh      <= TMZ_INH_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign rdData     = state.rdData;
	assign irq        = state.irq;
	assign wdtTimeout = state.wdtTimeout;
	assign portADir   = state.portADir;

	// checks, all on the one clock
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	property p_timer_inc;
		(!state.option.clockSourceSelect && state.option.dividerAssignment
			&& instrTick && !sleepMode && !wrCount && state.inh == TMZ_INH_IDLE)
		|=> state.count == $past(state.count) + 8'h01;
	endproperty
	a_timer_inc: assert property (p_timer_inc) else $error("timer missed a cycle");

	property p_write_hold;
		wrCount |=> (state.inh == TMZ_INH_HOLD2) && (state.count == $past(busReq.wrData));
	endproperty
	a_write_hold: assert property (p_write_hold) else $error("write not held");

	property p_hold_freeze;
		(state.inh != TMZ_INH_IDLE && !wrCount) |=> state.count == $past(state.count);
	endproperty
	a_hold_freeze: assert property (p_hold_freeze) else $error("count moved in hold");

	property p_edge_inc;
		(state.option.clockSourceSelect && !state.option.countEdgeSelect
			&& state.option.dividerAssignment && risePulse && !sleepMode
			&& !wrCount && state.inh == TMZ_INH_IDLE)
		|=> state.count == $past(state.count) + 8'h01;
	endproperty
	a_edge_inc: assert property (p_edge_inc) else $error("rising edge not counted");

	property p_overflow;
		(incTick && !wrCount && state.inh == TMZ_INH_IDLE && state.count == 8'hff)
		|=> state.intCtl[`TMZ_BIT_OVF_FLAG] && state.count == 8'h00;
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow flag missed");

	property p_irq_mask;
		irq == (state.intCtl[`TMZ_BIT_OVF_FLAG] && state.intCtl[`TMZ_BIT_OVF_EN]);
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq not gated by enable");

	property p_sleep_stop;
		(sleepMode && !wrCount) |=> state.count == $past(state.count);
	endproperty
	a_sleep_stop: assert property (p_sleep_stop) else $error("count moved in sleep");

	property p_mirror_read;
		(busReq.rdStrobe && busReq.addr == `TMZ_ADDR_COUNT_MIR)
		|=> rdData == $past(state.count);
	endproperty
	a_mirror_read: assert property (p_mirror_read) else $error("mirror read wrong");

	property p_write_mirror;
		(busReq.wrStrobe && busReq.addr == `TMZ_ADDR_COUNT_MIR)
		|=> state.count == $past(busReq.wrData);
	endproperty
	a_write_mirror: assert property (p_write_mirror) else $error("mirror write lost");

	property p_count_read;
		(busReq.rdStrobe && busReq.addr == `TMZ_ADDR_COUNT) |=> rdData == $past(state.count);
	endproperty
	a_count_read: assert property (p_count_read) else $error("count read wrong");

	property p_unmapped_read;
		(busReq.rdStrobe && sel == TMZ_SEL_NONE) |=> rdData == 8'h00;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read");

	property p_hold_step;
		(state.inh == TMZ_INH_HOLD2 && instrTick && !wrCount) |=> state.inh == TMZ_INH_HOLD1;
	endproperty
	a_hold_step: assert property (p_hold_step) else $error("hold did not step");

	property p_hold_exit;
		(state.inh == TMZ_INH_HOLD1 && instrTick && !wrCount)
		|=> state.inh == TMZ_INH_IDLE && state.count == $past(state.count);
	endproperty
	a_hold_exit: assert property (p_hold_exit) else $error("hold exit wrong");

	property p_hold_wait;
		(state.inh != TMZ_INH_IDLE && !instrTick && !wrCount) |=> state.inh == $past(state.inh);
	endproperty
	a_hold_wait: assert property (p_hold_wait) else $error("hold moved early");

	property p_fall_inc;
		(state.option.clockSourceSelect && state.option.countEdgeSelect
			&& state.option.dividerAssignment && fallPulse && !sleepMode
			&& !wrCount && state.inh == TMZ_INH_IDLE)
		|=> state.count == $past(state.count) + 8'h01;
	endproperty
	a_fall_inc: assert property (p_fall_inc) else $error("falling edge not counted");

	property p_pin_only;
		(state.option.clockSourceSelect && !risePulse && !fallPulse && !wrCount)
		|=> state.count == $past(state.count);
	endproperty
	a_pin_only: assert property (p_pin_only) else $error("count moved without edge");

	// edge pulses lag the pin by two samples; holds only if the pin idles low in reset
	property p_sync_delay;
		(risePulse == ($past(extCountPin, 2) && !$past(extCountPin, 3)))
		&& (fallPulse == (!$past(extCountPin, 2) && $past(extCountPin, 3)));
	endproperty
	a_sync_delay: assert property (p_sync_delay) else $error("sync delay wrong");

	property p_flag_sticky;
		(state.intCtl[`TMZ_BIT_OVF_FLAG] && !(busReq.wrStrobe && sel == TMZ_SEL_INTCTL
			&& busReq.wrData[`TMZ_BIT_OVF_FLAG]))
		|=> state.intCtl[`TMZ_BIT_OVF_FLAG];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

	property p_flag_clear;
		(busReq.wrStrobe && sel == TMZ_SEL_INTCTL && busReq.wrData[`TMZ_BIT_OVF_FLAG]
			&& !ovfSet)
		|=> !state.intCtl[`TMZ_BIT_OVF_FLAG];
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

	property p_no_stray_flag;
		(!state.intCtl[`TMZ_BIT_OVF_FLAG] && !ovfSet) |=> !state.intCtl[`TMZ_BIT_OVF_FLAG];
	endproperty
	a_no_stray_flag: assert property (p_no_stray_flag) else $error("flag set unasked");

	property p_wd_direct;
		(state.option.dividerAssignment && srcTick && !wrCount && state.inh == TMZ_INH_IDLE)
		|=> state.count == $past(state.count) + 8'h01;
	endproperty
	a_wd_direct: assert property (p_wd_direct) else $error("tick not applied");

	property p_div_gate;
		(!state.option.dividerAssignment && !divOut && !wrCount)
		|=> state.count == $past(state.count);
	endproperty
	a_div_gate: assert property (p_div_gate) else $error("count bypassed divider");

	property p_div_step;
		(!state.option.dividerAssignment && divOut && !wrCount && state.inh == TMZ_INH_IDLE)
		|=> state.count == $past(state.count) + 8'h01;
	endproperty
	a_div_step: assert property (p_div_step) else $error("divided tick lost");

	property p_wdt_pass;
		!state.option.dividerAssignment |=> wdtTimeout == $past(wdtTick);
	endproperty
	a_wdt_pass: assert property (p_wdt_pass) else $error("watchdog tick altered");

	property p_wdt_ratio1;
		(state.option.dividerAssignment && state.option.dividerRatio == 3'h0
			&& wdtTick && !wdtClear)
		|=> wdtTimeout;
	endproperty
	a_wdt_ratio1: assert property (p_wdt_ratio1) else $error("1:1 tick lost");

	property p_option_write;
		(busReq.wrStrobe && sel == TMZ_SEL_OPTION) |=> state.option == $past(busReq.wrData);
	endproperty
	a_option_write: assert property (p_option_write) else $error("option not taken");

	property p_count_clear_div;
		(!state.option.dividerAssignment && wrCount) |-> divClear;
	endproperty
	a_count_clear_div: assert property (p_count_clear_div) else $error("divider kept");

	property p_wdt_clear_div;
		(state.option.dividerAssignment && wdtClear) |-> divClear && !divOut;
	endproperty
	a_wdt_clear_div: assert property (p_wdt_clear_div) else $error("divider kept");

	c_overflow: cover property (ovfSet);
	c_write:    cover property (wrCount ##1 (state.inh == TMZ_INH_HOLD2) [*3]);
	c_edge:     cover property (state.option.clockSourceSelect && fallPulse && incTick);
	c_wd_div:   cover property (state.option.dividerAssignment && divOut);
	c_hold_end: cover property (state.inh == TMZ_INH_HOLD1 && instrTick);
endmodule : tmz_timer

// ===== sim/tmz_pin_source.sv
// Purpose: event source standing on the count pin
// Assumes: every level is held for whole clocks, so the synchroniser catches it
// Notes:   pin is always driven; it idles low, with no pull on the line
`timescale 1ns/1ps
module tmz_pin_source (
	input  wire logic clk,
	output logic      pin
);
	initial pin = 1'b0;

	// n rising edges, ending high; h is the hold per level, short or long
	task automatic rises(input int n, input int h);
		for (int i = 0; i < n; i++) begin
			if (i > 0) begin
				repeat (h) @(posedge clk);
				pin <= 1'b0;
			end
			repeat (h) @(posedge clk);
			pin <= 1'b1;
		end
	endtask : rises

	// one falling edge back to idle
	task automatic fall(input int h);
		repeat (h) @(posedge clk);
		pin <= 1'b0;
	endtask : fall
endmodule : tmz_pin_source

// ===== sim/tmz_timer_tb.sv
// Purpose: self-checking bench of the timer through its register port
// Assumes: short instruction cycle (4 clk) to keep the run brief
// Notes:   counts near tick boundaries are checked as ranges, phase is free
`timescale 1ns/1ps
`include "tmz_regs.svh"
module tmz_timer_tb import tmz_pkg::*;;
	localparam int IC = 4;
	logic         clk;
	logic         reset;
	tmz_bus_req_s busReq;
	logic [7:0]   rdData;
	logic [7:0]   v;
	logic [5:0]   portADir;
	logic         extCountPin;
	logic         sleepMode;
	logic         wdtTick;
	logic         wdtClear;
	logic         wdtTimeout;
	logic         irq;
	int           fails = 0;
	int           n_checks = 0;
	int           toCnt = 0;

	tmz_timer #(.INSTR_CYC(IC)) u_tmz_timer (.clk(clk), .reset(reset), .busReq(busReq),
		.rdData(rdData), .extCountPin(extCountPin), .sleepMode(sleepMode),
		.wdtTick(wdtTick), .wdtClear(wdtClear), .wdtTimeout(wdtTimeout), .irq(irq),
		.portADir(portADir));
	tmz_pin_source u_tmz_pin_source (.clk(clk), .pin(extCountPin));

	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// watchdog output pulses seen so far
	always @(posedge clk) begin
		if (wdtTimeout === 1'b1) toCnt <= toCnt + 1;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic chkr(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
		n_checks++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask : chkr

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge clk);
		busReq <= '{addr: a, wrData: d, wrStrobe: 1'b1, rdStrobe: 1'b0};
		@(posedge clk);
		busReq.wrStrobe <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [8:0] a, output logic [7:0] d);
		@(posedge clk);
		busReq <= '{addr: a, wrData: 8'h00, wrStrobe: 1'b0, rdStrobe: 1'b1};
		@(posedge clk);
		busReq.rdStrobe <= 1'b0;
		#1 d = rdData;
	endtask : rd

	task automatic rdc(input logic [8:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk(d, exp);
	endtask : rdc

	// irq is registered, so give the write two edges to land
	task automatic irqc(input logic exp);
		cyc(2);
		#1 chk({7'h00, irq}, {7'h00, exp});
	endtask : irqc

	task automatic wt(input int n);
		repeat (n) begin
			@(posedge clk);
			wdtTick <= 1'b1;
			@(posedge clk);
			wdtTick <= 1'b0;
		end
	endtask : wt

	task automatic clr();
		@(posedge clk);
		wdtClear <= 1'b1;
		@(posedge clk);
		wdtClear <= 1'b0;
	endtask : clr

	task automatic stop_test();
		if (fails == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : stop_test

	// reset values, mirrors, unmapped read; counter mode with a quiet pin
	task automatic t_reset();
		rdc(`TMZ_ADDR_COUNT, 8'h00);
		rdc(`TMZ_ADDR_INTCTL_M3, 8'h00);
		rdc(`TMZ_ADDR_OPTION, 8'hff);
		rdc(`TMZ_ADDR_PORTA_DIR, 8'h3f);
		chk({2'b00, portADir}, 8'h3f);
		rdc(9'h002, 8'h00);
		wr(`TMZ_ADDR_COUNT_MIR, 8'h5a);
		rdc(`TMZ_ADDR_COUNT, 8'h5a);
		wr(`TMZ_ADDR_COUNT, 8'ha5);
		rdc(`TMZ_ADDR_COUNT_MIR, 8'ha5);
	endtask : t_reset

	// timer mode, divider away: hold after a write, then one step per tick
	task automatic t_timer();
		wr(`TMZ_ADDR_OPTION_MIR, 8'h08);
		wr(`TMZ_ADDR_COUNT, 8'h10);
		cyc(2 * IC - 3);
		rdc(`TMZ_ADDR_COUNT, 8'h10);
		cyc(20 * IC);
		rd(`TMZ_ADDR_COUNT, v);
		chkr(v, 8'h23, 8'h25);
	endtask : t_timer

	task automatic t_sleep();
		@(posedge clk);
		sleepMode <= 1'b1;
		wr(`TMZ_ADDR_COUNT, 8'h40);
		cyc(10 * IC);
		rdc(`TMZ_ADDR_COUNT, 8'h40);
		@(posedge clk);
		sleepMode <= 1'b0;
	endtask : t_sleep

	// wrap while masked, then unmask, then clear by software
	task automatic t_ovf();
		int i;
		wr(`TMZ_ADDR_INTCTL, 8'h00);
		wr(`TMZ_ADDR_COUNT, 8'hfe);
		for (i = 0; i < 60; i++) begin
			rd(`TMZ_ADDR_INTCTL, v);
			if (v[2] === 1'b1) break;
		end
		// a timeout counts as a mismatch; the run carries on to the verdict
		if (i == 60) begin
			fails++;
		end else begin
			chk(v, 8'h04);
			rd(`TMZ_ADDR_COUNT, v);
			chkr(v, 8'h00, 8'h01);
			chk({7'h00, irq}, 8'h00);
			wr(`TMZ_ADDR_INTCTL_M1, 8'h20);
			irqc(1'b1);
			rdc(`TMZ_ADDR_INTCTL, 8'h24);
			wr(`TMZ_ADDR_INTCTL_M2, 8'h24);
			irqc(1'b0);
			rdc(`TMZ_ADDR_INTCTL, 8'h20);
		end
	endtask : t_ovf

	// falling then rising edge select, fast and slow pin levels
	task automatic t_edges();
		wr(`TMZ_ADDR_OPTION, 8'h38);
		wr(`TMZ_ADDR_COUNT, 8'h00);
		cyc(3 * IC);
		u_tmz_pin_source.rises(3, 4);
		cyc(8);
		rdc(`TMZ_ADDR_COUNT, 8'h02);
		u_tmz_pin_source.fall(4);
		cyc(8);
		rdc(`TMZ_ADDR_COUNT, 8'h03);
		wr(`TMZ_ADDR_OPTION, 8'h28);
		wr(`TMZ_ADDR_COUNT, 8'h00);
		cyc(3 * IC);
		u_tmz_pin_source.rises(3, 2);
		u_tmz_pin_source.fall(2);
		cyc(8);
		rdc(`TMZ_ADDR_COUNT, 8'h03);
		u_tmz_pin_source.rises(1, 2);
		rdc(`TMZ_ADDR_COUNT, 8'h03);
		cyc(8);
		rdc(`TMZ_ADDR_COUNT, 8'h04);
	endtask : t_edges

	// every ratio on the timer; window sized for four counts each
	task automatic t_div();
		for (int r = 0; r < 8; r++) begin
			wr(`TMZ_ADDR_OPTION, {5'b00000, 3'(r)});
			wr(`TMZ_ADDR_COUNT, 8'h00);
			cyc(((1 << (r + 1)) * 4 + 2) * IC);
			rd(`TMZ_ADDR_COUNT, v);
			chkr(v, 8'h03, 8'h05);
		end
	endtask : t_div

	// watchdog side of the shared divider
	task automatic t_wdt();
		int s;
		s = toCnt;
		wt(5);
		cyc(4);
		chk(8'(toCnt - s), 8'h05);
		wr(`TMZ_ADDR_COUNT, 8'h00);
		clr();
		for (int r = 0; r < 8; r++) begin
			wr(`TMZ_ADDR_OPTION, {5'b00001, 3'(r)});
			clr();
			s = toCnt;
			wt(3 << r);
			cyc(4);
			chk(8'(toCnt - s), 8'h03);
		end
		wr(`TMZ_ADDR_OPTION, 8'h0a);
		clr();
		s = toCnt;
		wt(3);
		clr();
		wt(3);
		cyc(4);
		chk(8'(toCnt - s), 8'h00);
	endtask : t_wdt

	// main sequence: reset 5 clocks, then each scenario in turn
	initial begin
		reset = 1'b1;
		busReq = '0;
		sleepMode = 1'b0;
		wdtTick = 1'b0;
		wdtClear = 1'b0;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_timer();
		t_sleep();
		t_ovf();
		t_edges();
		t_div();
		t_wdt();
		stop_test();
	end
endmodule : tmz_timer_tb
